// ### stam_params.svh
`ifndef STAM_PARAMS_SVH
`define STAM_PARAMS_SVH

// register offsets on the serial control port
`define STAM_ADDR_W         13
`define STAM_OFS_SYNC_CTRL  13'h005B
`define STAM_OFS_TMR_LO     13'h005C
`define STAM_OFS_TMR_HI     13'h005D
`define STAM_OFS_SREF_MISC  13'h005E
`define STAM_OFS_EXT_VCO    13'h0064
`define STAM_OFS_ADLY       13'h0065
`define STAM_OFS_FL_MASK    13'h0070
`define STAM_OFS_GEN_MASK   13'h0071
`define STAM_OFS_ALARM_RB   13'h007B

// reset values
`define STAM_RST_REG        8'h00

// field positions
`define STAM_BIT_SYNC_POL   0
`define STAM_BIT_SYNC_THRU  1
`define STAM_BIT_SYNC_RTM   2
`define STAM_BIT_VCO_LOWF   0
`define STAM_BIT_VCO_DIV2   1
`define STAM_BIT_ADLY_LP    0
`define STAM_BIT_ALARM_RB   0

// serial frame: rw, two length bits, 13 address bits, 8 data bits
`define STAM_FRAME_BITS     5'd24
`define STAM_HDR_BITS       5'd16
`define STAM_HDR_RW_POS     15

`endif

// ### stam_pkg.sv
package stam_pkg;
   // loop one status group, order matches its mask register
   typedef struct packed {
      logic       near_lock;
      logic       lock_acq;
      logic       lock_det;
      logic       holdover;
      logic [3:0] loss_of_signal;
   } stam_fl_stat_t;

   // general status group, order matches its mask register
   typedef struct packed {
      logic sync_req;
      logic both_lock;
      logic phase_stat;
      logic sysref_sync;
      logic sl_lock;
   } stam_gen_stat_t;

   typedef enum logic {SP_IDLE, SP_SHIFT} stam_spi_state_t;
endpackage

// ### stam_regs.sv
`include "stam_params.svh"

module stam_regs
(
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   input  wire logic                    sclk,
   input  wire logic                    ser_sel_n,
   input  wire logic                    sdio_in,
   output logic                         sdio_out,
   output logic                         sdio_oe,
   input  wire logic                    ext_sync,
   input  wire logic                    ref_zero_tick,
   input  wire stam_pkg::stam_fl_stat_t  fl_stat,
   input  wire stam_pkg::stam_gen_stat_t gen_stat,
   output logic                         sync_event_q,
   output logic                         reseed_second_loop_q,
   output logic                         beat_q,
   output logic                         ext_vco_div2_q,
   output logic                         ext_vco_class_a_q,
   output logic                         adly_low_power_q,
   output logic                         alarm_q
);
   import stam_pkg::*;

   logic [7:0]              sync_ctrl_q;
   logic [7:0]              tmr_lo_q;
   logic [7:0]              tmr_hi_q;
   logic [7:0]              sref_misc_q;
   logic [7:0]              ext_vco_q;
   logic [7:0]              adly_q;
   logic [7:0]              fl_mask_q;
   logic [7:0]              gen_mask_q;
   logic [7:0]              rdata_q;
   logic                    wr_stb;
   logic                    rd_stb;
   logic [`STAM_ADDR_W-1:0] addr;
   logic [7:0]              wdata;
   logic [11:0]             period;
   logic [11:0]             cnt_q;
   logic                    beat_tick;
   logic                    sync_lvl_q;
   logic                    sync_prev_q;
   logic                    sync_pend_q;
   logic                    sync_edge;

   // true when a write strobe hits the given offset
   function automatic logic wr_hit(input logic [`STAM_ADDR_W-1:0] ofs);
      wr_hit = wr_stb && (addr == ofs);
   endfunction

   stam_spi_slave u_spi
   (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .sclk      (sclk),
      .ser_sel_n (ser_sel_n),
      .sdio_in   (sdio_in),
      .sdio_out  (sdio_out),
      .sdio_oe   (sdio_oe),
      .wr_stb    (wr_stb),
      .rd_stb    (rd_stb),
      .addr      (addr),
      .wdata     (wdata),
      .rdata     (rdata_q)
   );

   // control registers, whole bytes kept so reserved bits read back
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         sync_ctrl_q <= `STAM_RST_REG;
         tmr_lo_q    <= `STAM_RST_REG;
         tmr_hi_q    <= `STAM_RST_REG;
         sref_misc_q <= `STAM_RST_REG;
         ext_vco_q   <= `STAM_RST_REG;
         adly_q      <= `STAM_RST_REG;
         fl_mask_q   <= `STAM_RST_REG;
         gen_mask_q  <= `STAM_RST_REG;
      end
      else
      begin
         if (wr_hit(`STAM_OFS_SYNC_CTRL)) sync_ctrl_q <= wdata;
         if (wr_hit(`STAM_OFS_TMR_LO))    tmr_lo_q    <= wdata;
         if (wr_hit(`STAM_OFS_TMR_HI))    tmr_hi_q    <= wdata;
         if (wr_hit(`STAM_OFS_SREF_MISC)) sref_misc_q <= wdata;
         if (wr_hit(`STAM_OFS_EXT_VCO))   ext_vco_q   <= wdata;
         if (wr_hit(`STAM_OFS_ADLY))      adly_q      <= wdata;
         if (wr_hit(`STAM_OFS_FL_MASK))   fl_mask_q   <= wdata;
         if (wr_hit(`STAM_OFS_GEN_MASK))  gen_mask_q  <= wdata;
      end
   end

   // read mux, captured once the header is in; unmapped reads give zero
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         rdata_q <= 8'h00;
      else if (rd_stb)
      begin
         case (addr)
            `STAM_OFS_SYNC_CTRL: rdata_q <= sync_ctrl_q;
            `STAM_OFS_TMR_LO:    rdata_q <= tmr_lo_q;
            `STAM_OFS_TMR_HI:    rdata_q <= tmr_hi_q;
            `STAM_OFS_SREF_MISC: rdata_q <= sref_misc_q;
            `STAM_OFS_EXT_VCO:   rdata_q <= ext_vco_q;
            `STAM_OFS_ADLY:      rdata_q <= adly_q;
            `STAM_OFS_FL_MASK:   rdata_q <= fl_mask_q;
            `STAM_OFS_GEN_MASK:  rdata_q <= gen_mask_q;
            `STAM_OFS_ALARM_RB:  rdata_q <= {7'h00, alarm_q};
            default:             rdata_q <= 8'h00;
         endcase
      end
   end

   // beat period from the setpoint; zero treated as one to avoid a stall
   assign period    = {tmr_hi_q[3:0], tmr_lo_q} == 12'h000 ? 12'h001
                                                           : {tmr_hi_q[3:0], tmr_lo_q};
   assign beat_tick = (cnt_q == 12'h000);

   // master timer; a new setpoint takes effect at the next reload
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         cnt_q  <= 12'h000;
         beat_q <= 1'b0;
      end
      else
      begin
         cnt_q  <= beat_tick ? period - 12'h001 : cnt_q - 12'h001;
         beat_q <= beat_tick;
      end
   end

   // sync sampling: polarity, then optional retime on reference zero
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         sync_lvl_q  <= 1'b0;
         sync_prev_q <= 1'b0;
      end
      else
      begin
         if (!sync_ctrl_q[`STAM_BIT_SYNC_RTM] || ref_zero_tick)
            sync_lvl_q <= ext_sync ^ sync_ctrl_q[`STAM_BIT_SYNC_POL];
         sync_prev_q <= sync_lvl_q;
      end
   end

   assign sync_edge = sync_lvl_q & ~sync_prev_q;

   // pending sync waits for a beat; a new edge wins over the clear
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         sync_pend_q          <= 1'b0;
         sync_event_q         <= 1'b0;
         reseed_second_loop_q <= 1'b0;
      end
      else
      begin
         sync_pend_q          <= sync_edge | (sync_pend_q & ~beat_tick);
         sync_event_q         <= sync_pend_q & beat_tick;
         reseed_second_loop_q <= sync_pend_q & beat_tick
                                 & sync_ctrl_q[`STAM_BIT_SYNC_THRU];
      end
   end

   // analog option levels, one register stage from the control bytes
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ext_vco_div2_q    <= 1'b0;
         ext_vco_class_a_q <= 1'b0;
         adly_low_power_q  <= 1'b0;
      end
      else
      begin
         ext_vco_div2_q    <= ext_vco_q[`STAM_BIT_VCO_DIV2];
         ext_vco_class_a_q <= ext_vco_q[`STAM_BIT_VCO_LOWF];
         adly_low_power_q  <= adly_q[`STAM_BIT_ADLY_LP];
      end
   end

   // combined alarm; struct order lines up with the mask bits
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         alarm_q <= 1'b0;
      else
         alarm_q <= |(fl_mask_q & fl_stat) | |(gen_mask_q[4:0] & gen_stat);
   end

   // helper for beat spacing check
   logic [12:0] gap_q;
   logic [11:0] ld_q;
   logic [11:0] ldp_q;
   logic [1:0]  armed_q;
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         gap_q   <= 13'h0000;
         ld_q    <= 12'h000;
         ldp_q   <= 12'h000;
         armed_q <= 2'h0;
      end
      else
      begin
         gap_q <= beat_q ? 13'h0001 : gap_q + 13'h0001;
         if (beat_tick)
         begin
            ld_q  <= period;
            ldp_q <= ld_q;
         end
         if (beat_q && armed_q != 2'h3)
            armed_q <= armed_q + 2'h1;
      end
   end

   a_beat_spacing: assert property (@(posedge sys_clk) disable iff (!rst_n)
      beat_q && armed_q == 2'h3 |-> gap_q == {1'b0, ldp_q})
      else $error("beat spacing differs from setpoint");

   a_sync_on_beat: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sync_event_q |-> beat_q)
      else $error("sync event off the beat");

   a_retime_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sync_ctrl_q[`STAM_BIT_SYNC_RTM] && !ref_zero_tick |=> $stable(sync_lvl_q))
      else $error("retimed sync moved without reference tick");

   a_bypass_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !sync_ctrl_q[`STAM_BIT_SYNC_RTM] && $stable(sync_ctrl_q)
      |=> sync_lvl_q == ($past(ext_sync) ^ $past(sync_ctrl_q[`STAM_BIT_SYNC_POL])))
      else $error("bypassed sync not following input with polarity");

   a_reseed_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sync_event_q && $past(sync_ctrl_q[`STAM_BIT_SYNC_THRU]) |-> reseed_second_loop_q)
      else $error("reseed not routed to second loop");

   a_reseed_block: assert property (@(posedge sys_clk) disable iff (!rst_n)
      reseed_second_loop_q |-> sync_event_q && $past(sync_ctrl_q[`STAM_BIT_SYNC_THRU]))
      else $error("reseed without enable");

   a_timer_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_stb && addr == `STAM_OFS_TMR_HI
      |=> period[11:8] == $past(wdata[3:0]) || period == 12'h001)
      else $error("setpoint high nibble not taken");

   a_vco_options: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_stb && addr == `STAM_OFS_EXT_VCO |-> ##2 ext_vco_div2_q == $past(wdata[1], 2)
                                              && ext_vco_class_a_q == $past(wdata[0], 2))
      else $error("external VCO option not applied");

   a_adly_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_stb && addr == `STAM_OFS_ADLY |-> ##2 adly_low_power_q == $past(wdata[0], 2))
      else $error("analog delay mode not applied");

   a_alarm_near: assert property (@(posedge sys_clk) disable iff (!rst_n)
      fl_mask_q[7] && fl_stat.near_lock |=> alarm_q)
      else $error("masked-in near lock did not raise alarm");

   a_alarm_los: assert property (@(posedge sys_clk) disable iff (!rst_n)
      |(fl_mask_q[3:0] & fl_stat.loss_of_signal) |=> alarm_q)
      else $error("masked-in loss of signal did not raise alarm");

   a_alarm_gen: assert property (@(posedge sys_clk) disable iff (!rst_n)
      gen_mask_q[0] && gen_stat.sl_lock |=> alarm_q)
      else $error("masked-in second lock did not raise alarm");

   a_alarm_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
      fl_mask_q == 8'h00 && gen_mask_q[4:0] == 5'h00 |=> !alarm_q)
      else $error("alarm active with all masks clear");

   a_alarm_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rd_stb && addr == `STAM_OFS_ALARM_RB |=> rdata_q == {7'h00, $past(alarm_q)})
      else $error("alarm readback wrong");

   a_reserved_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_stb && addr == `STAM_OFS_SREF_MISC |=> sref_misc_q == $past(wdata))
      else $error("reserved register not stored");
endmodule

// ### stam_regs_tb.sv
`include "stam_params.svh"

module stam_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import stam_pkg::*;

   localparam int HALF = 5; // sclk half period, above the three-cycle minimum
   logic           sys_clk       = 1'b0;
   logic           rst_n         = 1'b0;
   logic           sclk          = 1'b0;
   logic           ser_sel_n     = 1'b1;
   logic           mst_d         = 1'b0;
   logic           sdio_in;
   logic           sdio_out;
   logic           sdio_oe;
   logic           ext_sync      = 1'b0;
   logic           ref_zero_tick = 1'b0;
   stam_fl_stat_t  fl_stat       = '0;
   stam_gen_stat_t gen_stat      = '0;
   logic           sync_event_q;
   logic           reseed_second_loop_q;
   logic           beat_q;
   logic           ext_vco_div2_q;
   logic           ext_vco_class_a_q;
   logic           adly_low_power_q;
   logic           alarm_q;
   int             n_errors = 0;
   int             n_checks = 0;
   int             gap;
   logic [12:0]    ofs [8] = '{`STAM_OFS_SYNC_CTRL, `STAM_OFS_TMR_LO, `STAM_OFS_TMR_HI,
                               `STAM_OFS_SREF_MISC, `STAM_OFS_EXT_VCO, `STAM_OFS_ADLY,
                               `STAM_OFS_FL_MASK, `STAM_OFS_GEN_MASK};
   logic [7:0]     pat [8] = '{8'hF8, 8'hA5, 8'h5A, 8'hC3, 8'hFC, 8'hFE, 8'h96, 8'hE9};

   always #12.5 sys_clk = ~sys_clk;

   // shared data wire: the block wins while it drives, otherwise the master level
   assign sdio_in = sdio_oe ? sdio_out : mst_d;

   stam_regs u_stam_regs
   (
      .sys_clk              (sys_clk),
      .rst_n                (rst_n),
      .sclk                 (sclk),
      .ser_sel_n            (ser_sel_n),
      .sdio_in              (sdio_in),
      .sdio_out             (sdio_out),
      .sdio_oe              (sdio_oe),
      .ext_sync             (ext_sync),
      .ref_zero_tick        (ref_zero_tick),
      .fl_stat              (fl_stat),
      .gen_stat             (gen_stat),
      .sync_event_q         (sync_event_q),
      .reseed_second_loop_q (reseed_second_loop_q),
      .beat_q               (beat_q),
      .ext_vco_div2_q       (ext_vco_div2_q),
      .ext_vco_class_a_q    (ext_vco_class_a_q),
      .adly_low_power_q     (adly_low_power_q),
      .alarm_q              (alarm_q)
   );

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
      end
   endtask

   task automatic chk_num(input int got, input int exp);
      n_checks++;
      if (got != exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t count got %0d exp %0d", $time, got, exp);
      end
   endtask

   // one 24-bit frame; read data is sampled just before each rise, as the master does
   task automatic spi_xfer(input logic rw, input logic [12:0] a, input logic [7:0] d,
                           output logic [7:0] q);
      logic [23:0] w;
      w = {rw, 2'b00, a, d};
      q = 8'h00;
      @(posedge sys_clk) ser_sel_n <= 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         @(posedge sys_clk);
         mst_d <= (rw && i < 8) ? ~mst_d : w[i]; // released master keeps toggling
         repeat (HALF) @(posedge sys_clk);
         if (i < 8)
         begin
            q[i] = sdio_in;
            chk_bit(sdio_oe, rw);
         end
         sclk <= 1'b1;
         repeat (HALF) @(posedge sys_clk);
         sclk <= 1'b0;
      end
      repeat (HALF) @(posedge sys_clk);
      ser_sel_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      logic [7:0] q;
      spi_xfer(1'b0, a, d, q);
   endtask

   task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
      logic [7:0] q;
      spi_xfer(1'b1, a, 8'h00, q);
      chk_byte(q, exp);
   endtask

   // alarm is registered: let inputs settle a couple of edges first
   task automatic alarm_chk(input logic exp);
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk_bit(alarm_q, exp);
   endtask

   // cycles between two beats, bounded so a dead timer cannot hang the run
   task automatic beat_gap(output int n);
      int c;
      c = 0;
      @(negedge sys_clk);
      while (beat_q !== 1'b1 && c < 5000)
      begin
         @(negedge sys_clk);
         c++;
      end
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (beat_q !== 1'b1 && n < 5000);
   endtask

   // count sync and reseed pulses; a sync pulse off a beat is always wrong
   task automatic sync_watch(input int es, input int er);
      int ns;
      int nr;
      int nb;
      ns = 0;
      nr = 0;
      nb = 0;
      repeat (30)
      begin
         @(negedge sys_clk);
         ns += (sync_event_q === 1'b1);
         nr += (reseed_second_loop_q === 1'b1);
         nb += (sync_event_q === 1'b1 && beat_q !== 1'b1);
      end
      chk_num(ns, es);
      chk_num(nr, er);
      chk_num(nb, 0);
   endtask

   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // watchdog: the tests need about 19k cycles, so 50k means a hang
   initial
   begin
      repeat (50000) @(posedge sys_clk);
      n_errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      complete_run();
   end

   initial
   begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      // reset values, then full-width patterns including reserved bits
      foreach (ofs[k]) rd_chk(ofs[k], 8'h00);
      foreach (ofs[k]) wr(ofs[k], pat[k]);
      foreach (ofs[k]) rd_chk(ofs[k], pat[k]);
      @(negedge sys_clk);
      chk_bit(ext_vco_div2_q, 1'b0);
      chk_bit(adly_low_power_q, 1'b0);
      wr(13'h0060, 8'hFF);
      rd_chk(13'h0060, 8'h00);
      wr(`STAM_OFS_ALARM_RB, 8'hFF);
      rd_chk(`STAM_OFS_ALARM_RB, 8'h00);
      // every combination of the two external VCO path bits
      for (int v = 0; v < 4; v++)
      begin
         wr(`STAM_OFS_EXT_VCO, 8'(v));
         @(negedge sys_clk);
         chk_bit(ext_vco_div2_q, v[1]);
         chk_bit(ext_vco_class_a_q, v[0]);
      end
      wr(`STAM_OFS_ADLY, 8'h01);
      @(negedge sys_clk);
      chk_bit(adly_low_power_q, 1'b1);
      wr(`STAM_OFS_ADLY, 8'h00);
      @(negedge sys_clk);
      chk_bit(adly_low_power_q, 1'b0);
      // every status active but every mask clear
      wr(`STAM_OFS_FL_MASK, 8'h00);
      wr(`STAM_OFS_GEN_MASK, 8'h00);
      fl_stat <= '1;
      gen_stat <= '1;
      alarm_chk(1'b0);
      // one mask bit open: only its own status may raise the alarm
      for (int k = 0; k < 8; k++)
      begin
         wr(`STAM_OFS_FL_MASK, 8'h01 << k);
         fl_stat <= stam_fl_stat_t'(8'h01 << k);
         alarm_chk(1'b1);
         rd_chk(`STAM_OFS_ALARM_RB, 8'h01);
         fl_stat <= stam_fl_stat_t'(~(8'h01 << k));
         alarm_chk(1'b0);
      end
      wr(`STAM_OFS_FL_MASK, 8'h00);
      for (int k = 0; k < 5; k++)
      begin
         wr(`STAM_OFS_GEN_MASK, 8'h01 << k);
         gen_stat <= stam_gen_stat_t'(5'h01 << k);
         alarm_chk(1'b1);
         gen_stat <= stam_gen_stat_t'(~(5'h01 << k));
         alarm_chk(1'b0);
      end
      rd_chk(`STAM_OFS_ALARM_RB, 8'h00);
      // twelve-bit setpoint, reserved upper nibble set on purpose
      wr(`STAM_OFS_TMR_LO, 8'h03);
      wr(`STAM_OFS_TMR_HI, 8'hF1);
      beat_gap(gap);
      chk_num(gap, 259);
      // 40 MHz over ten gives the 4 MHz ceiling for the beat
      wr(`STAM_OFS_TMR_HI, 8'h00);
      wr(`STAM_OFS_TMR_LO, 8'h0A);
      beat_gap(gap);
      chk_num(gap, 10);
      // sync edges: straight path, polarity, second loop, retime
      wr(`STAM_OFS_SYNC_CTRL, 8'h00);
      ext_sync <= 1'b1;
      sync_watch(1, 0);
      wr(`STAM_OFS_SYNC_CTRL, 8'h01);
      sync_watch(0, 0);
      ext_sync <= 1'b0;
      sync_watch(1, 0);
      ext_sync <= 1'b1;
      sync_watch(0, 0);
      ext_sync <= 1'b0;
      sync_watch(1, 0);
      wr(`STAM_OFS_SYNC_CTRL, 8'h02);
      ext_sync <= 1'b1;
      sync_watch(1, 1);
      ext_sync <= 1'b0;
      sync_watch(0, 0);
      wr(`STAM_OFS_SYNC_CTRL, 8'h04);
      ext_sync <= 1'b1;
      sync_watch(0, 0);
      ref_zero_tick <= 1'b1;
      @(posedge sys_clk);
      ref_zero_tick <= 1'b0;
      sync_watch(1, 0);
      complete_run();
   end
endmodule

// ### stam_spi_slave.sv
`include "stam_params.svh"

module stam_spi_slave
(
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   input  wire logic                     sclk,
   input  wire logic                     ser_sel_n,
   input  wire logic                     sdio_in,
   output logic                          sdio_out,
   output logic                          sdio_oe,
   output logic                          wr_stb,
   output logic                          rd_stb,
   output logic [`STAM_ADDR_W-1:0]       addr,
   output logic [7:0]                    wdata,
   input  wire logic [7:0]               rdata
);
   import stam_pkg::*;

   stam_spi_state_t st_q;
   logic            sclk_prev_q;
   logic [4:0]      cnt_q;
   logic [23:0]     sh_q;
   logic            rd_q;
   logic [7:0]      rd_sh_q;
   logic            rise;
   logic            fall;

   assign rise = sclk & ~sclk_prev_q;
   assign fall = ~sclk & sclk_prev_q;

   // edge detect on the serial clock, which is sampled as a plain input
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         sclk_prev_q <= 1'b0;
      else
         sclk_prev_q <= sclk;
   end

   // frame shifter and strobes
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         st_q   <= SP_IDLE;
         cnt_q  <= 5'h00;
         sh_q   <= 24'h000000;
         rd_q   <= 1'b0;
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         addr   <= '0;
         wdata  <= 8'h00;
      end
      else
      begin
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         case (st_q)
            SP_IDLE:
            begin
               cnt_q <= 5'h00;
               if (!ser_sel_n)
                  st_q <= SP_SHIFT;
            end
            SP_SHIFT:
            begin
               if (ser_sel_n)
                  st_q <= SP_IDLE;
               else if (rise && cnt_q < `STAM_FRAME_BITS)
               begin
                  sh_q  <= {sh_q[22:0], sdio_in};
                  cnt_q <= cnt_q + 5'd1;
                  if (cnt_q == `STAM_HDR_BITS - 5'd1)
                  begin
                     // header complete: rw decides read or write
                     addr   <= {sh_q[11:0], sdio_in};
                     rd_q   <= sh_q[`STAM_HDR_RW_POS-1];
                     rd_stb <= sh_q[`STAM_HDR_RW_POS-1];
                  end
                  if (cnt_q == `STAM_FRAME_BITS - 5'd1 && !rd_q)
                  begin
                     wdata  <= {sh_q[6:0], sdio_in};
                     wr_stb <= 1'b1;
                  end
               end
            end
            default: st_q <= SP_IDLE;
         endcase
      end
   end

   // read data leaves on falling edges; needs a slow serial clock
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n || ser_sel_n)
      begin
         sdio_out <= 1'b0;
         sdio_oe  <= 1'b0;
         rd_sh_q  <= 8'h00;
      end
      else if (fall && rd_q && cnt_q >= `STAM_HDR_BITS && cnt_q < `STAM_FRAME_BITS)
      begin
         sdio_oe <= 1'b1;
         if (cnt_q == `STAM_HDR_BITS)
         begin
            sdio_out <= rdata[7];
            rd_sh_q  <= {rdata[6:0], 1'b0};
         end
         else
         begin
            sdio_out <= rd_sh_q[7];
            rd_sh_q  <= {rd_sh_q[6:0], 1'b0};
         end
      end
   end
endmodule
